/* File: hw/rsbc_pkg.sv */
package rsbc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] RSBC_ADDR_CONFIG = 12'h000;
	localparam logic [11:0] RSBC_ADDR_FREQ   = 12'h004;
	localparam logic [11:0] RSBC_ADDR_STRAPS = 12'h008;
	localparam logic [11:0] RSBC_ADDR_CTRL   = 12'h00C;

	// ****************************************************************
	// Strap vector layout
	// ****************************************************************
	localparam int RSBC_STRAP_W = 14;
	localparam logic [13:0] RSBC_PULLUP_MASK = 14'h2E00;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	typedef enum logic [1:0]
	{
		RSBC_CLK_RF     = 2'h0,
		RSBC_CLK_RTC    = 2'h1,
		RSBC_CLK_EXT    = 2'h2,
		RSBC_CLK_ACQ    = 2'h3
	} rsbc_bootclk_e;

	typedef enum logic [2:0]
	{
		RSBC_F_13P0     = 3'h0,
		RSBC_F_16P369   = 3'h1,
		RSBC_F_16P8     = 3'h2,
		RSBC_F_19P2     = 3'h3,
		RSBC_F_24P5535  = 3'h4,
		RSBC_F_26P0     = 3'h5,
		RSBC_F_33P6     = 3'h6,
		RSBC_F_NONE     = 3'h7
	} rsbc_freq_e;

	localparam logic [4:0] RSBC_EXT_13P0 = 5'h00;
	localparam logic [4:0] RSBC_EXT_16P8 = 5'h08;
	localparam logic [4:0] RSBC_EXT_19P2 = 5'h0D;
	localparam logic [4:0] RSBC_EXT_33P6 = 5'h1E;

	// ****************************************************************
	// Decoded configuration
	// ****************************************************************
	typedef struct packed
	{
		logic          boot_internal;
		logic          rf_integrated;
		rsbc_bootclk_e boot_clock;
		logic          bus_reserved;
		rsbc_freq_e    freq;
		logic          freq_unsupported;
	} rsbc_cfg_s;

	localparam rsbc_cfg_s RSBC_CFG_RESET = '{1'b0, 1'b1, RSBC_CLK_ACQ, 1'b0,
		RSBC_F_16P369, 1'b0};

	localparam logic [1:0] RSBC_TST_01 = 2'h1;
	localparam logic [1:0] RSBC_TST_00 = 2'h0;
	localparam logic [1:0] RSBC_TST_10 = 2'h2;

endpackage

/* File: hw/rsbc_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module rsbc_decode
	import rsbc_pkg::*;
(
	input  wire logic [13:0] straps,
	input  wire logic [1:0]  test_straps,
	output var rsbc_cfg_s    cfg
);

	always_comb
	begin
		cfg.boot_internal = straps[0];                            // R2
		cfg.rf_integrated = straps[1];                            // R3
		cfg.boot_clock    = rsbc_bootclk_e'({straps[3], straps[2]}); // R4
		cfg.bus_reserved  = straps[7];                            // R5
		cfg.freq_unsupported = 1'b0;
		if (test_straps == RSBC_TST_01)
		begin
			cfg.freq = RSBC_F_24P5535;                            // R6
		end
		else if (test_straps == RSBC_TST_00)
		begin
			cfg.freq = RSBC_F_16P369;                             // R6
		end
		else if (test_straps == RSBC_TST_10)
		begin
			cfg.freq = RSBC_F_26P0;                               // R6
		end
		else if (straps[13:9] == RSBC_EXT_13P0)
		begin
			cfg.freq = RSBC_F_13P0;                               // R7
		end
		else if (straps[13:9] == RSBC_EXT_16P8)
		begin
			cfg.freq = RSBC_F_16P8;                               // R7
		end
		else if (straps[13:9] == RSBC_EXT_19P2)
		begin
			cfg.freq = RSBC_F_19P2;                               // R7
		end
		else if (straps[13:9] == RSBC_EXT_33P6)
		begin
			cfg.freq = RSBC_F_33P6;                               // R7
		end
		else
		begin
			cfg.freq             = RSBC_F_NONE;                   // R13
			cfg.freq_unsupported = 1'b1;                          // R13
		end
	end

endmodule
`default_nettype wire

/* File: hw/rsbc_top.sv */
// Summary of operation
// R1: Data bus straps sampled during reset, latched for the session; the code samples them at the first clock after release.
// R2: Boot source strap: 1 internal boot memory, 0 external.
// R3: RF variant strap: 0 older separate chip, 1 integrated front end.
// R4: Boot clock {hi,lo}: 00 RF, 01 RTC, 10 external, 11 acquisition.
// R5: Bus width strap: 0 selects 16 bit, 1 reserved.
// R6: Test straps 01, 00, 10 select 24.5535, 16.369, 26 MHz.
// R7: Test straps 11: extended 00000,01000,01101,11110 give 13,16.8,19.2,33.6.
// R8: Board straps bus 0, clock 11, RF type 1, boot 0.
// R9: Internal pull-ups on extended straps 13, 11, 10, 9.
// R10: Board sets every strap with external resistor.
// R11: Reference oscillator clock used as boot clock; the code selects it after reset, but a write of 0 to CTRL bit 0 turns it off.
// R12: Latched values constant after reset; bus returns to normal.
// R13: Unlisted frequency straps flagged unsupported.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rsbc_top
	import rsbc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [13:0] data_bus_in,
	input  wire logic [13:0] data_bus_drive,
	input  wire logic        test_clock_freq_strap,
	input  wire logic        test_datain_freq_strap,
	output logic             boot_internal,
	output logic             rf_integrated,
	output logic [1:0]       boot_clock_sel,
	output logic             bus_width_reserved,
	output logic [2:0]       ref_freq_sel,
	output logic             freq_unsupported,
	output logic             config_valid,
	output logic             use_ref_as_boot_clock
);

	// ****************************************************************
	// Strap capture
	// ****************************************************************
	logic [13:0] strap_reg;
	logic [13:0] strap_next;
	logic [1:0]  test_reg;
	logic [1:0]  test_next;
	logic        captured_reg;
	logic        captured_next;
	logic [13:0] strap_level;
	rsbc_cfg_s   dec_cfg;
	rsbc_cfg_s   cfg_reg;
	rsbc_cfg_s   cfg_next;
	logic        ref_boot_reg;
	logic        ref_boot_next;

	// Undriven pulled-up pins read as one
	always_comb
	begin
		strap_level = (data_bus_in & data_bus_drive)
			| (RSBC_PULLUP_MASK & ~data_bus_drive);                  // R9
	end

	// First clock after release takes the straps, then frozen
	always_comb
	begin
		strap_next    = strap_reg;
		test_next     = test_reg;
		captured_next = captured_reg;
		if (!captured_reg)
		begin
			strap_next    = strap_level;                              // R1
			test_next     = {test_clock_freq_strap, test_datain_freq_strap}; // R1
			captured_next = 1'b1;                                     // R12
		end
	end

	rsbc_decode u_decode
	(
		.straps      (strap_reg),
		.test_straps (test_reg),
		.cfg         (dec_cfg)
	);

	// ****************************************************************
	// Configuration and control
	// ****************************************************************
	logic        ctrl_ref_reg;
	logic        ctrl_ref_next;
	logic        valid_reg;
	logic        valid_next;

	always_comb
	begin
		cfg_next      = cfg_reg;
		valid_next    = valid_reg;
		ctrl_ref_next = ctrl_ref_reg;
		if (captured_reg && !valid_reg)
		begin
			cfg_next   = dec_cfg;                                      // R12
			valid_next = 1'b1;
		end
		if (psel && penable && pwrite && paddr == RSBC_ADDR_CTRL)
		begin
			ctrl_ref_next = pwdata[0];
		end
		ref_boot_next = ctrl_ref_reg;                                  // R11
	end

	// ****************************************************************
	// APB read path
	// ****************************************************************
	logic [31:0] rdata_next;
	logic        err_next;

	always_comb
	begin
		rdata_next = 32'h0000_0000;
		err_next   = 1'b0;
		if (paddr == RSBC_ADDR_CONFIG)
		begin
			rdata_next[5:0] = {cfg_reg.bus_reserved, cfg_reg.boot_clock,
				cfg_reg.rf_integrated, cfg_reg.boot_internal, valid_reg};
		end
		else if (paddr == RSBC_ADDR_FREQ)
		begin
			rdata_next[3:0] = {cfg_reg.freq_unsupported, cfg_reg.freq};  // R13
		end
		else if (paddr == RSBC_ADDR_STRAPS)
		begin
			rdata_next[15:0] = {test_reg, strap_reg};
		end
		else if (paddr == RSBC_ADDR_CTRL)
		begin
			rdata_next[0] = ctrl_ref_reg;
		end
		else
		begin
			err_next = 1'b1;
		end
		if (!(psel && !penable) || pwrite)
		begin
			rdata_next = prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_reg    <= 14'h0000;
			test_reg     <= 2'h0;
			captured_reg <= 1'b0;
			cfg_reg      <= RSBC_CFG_RESET;
			valid_reg    <= 1'b0;
			ctrl_ref_reg <= 1'b1;
			ref_boot_reg <= 1'b1;
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
		end
		else
		begin
			strap_reg    <= strap_next;
			test_reg     <= test_next;
			captured_reg <= captured_next;
			cfg_reg      <= cfg_next;
			valid_reg    <= valid_next;
			ctrl_ref_reg <= ctrl_ref_next;
			ref_boot_reg <= ref_boot_next;
			prdata       <= rdata_next;
			pready       <= psel && !penable;
			pslverr      <= (psel && !penable) ? err_next : 1'b0;
		end
	end

	// ****************************************************************
	// Configuration outputs
	// ****************************************************************
	always_comb
	begin
		boot_internal         = cfg_reg.boot_internal;               // R2
		rf_integrated         = cfg_reg.rf_integrated;               // R3
		boot_clock_sel        = cfg_reg.boot_clock;                  // R4
		bus_width_reserved    = cfg_reg.bus_reserved;                // R5
		ref_freq_sel          = cfg_reg.freq;
		freq_unsupported      = cfg_reg.freq_unsupported;            // R13
		config_valid          = valid_reg;
		use_ref_as_boot_clock = ref_boot_reg;
	end

endmodule
`default_nettype wire

/* File: bench/rsbc_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module rsbc_top_props
	import rsbc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        boot_internal,
	input wire logic        rf_integrated,
	input wire logic [1:0]  boot_clock_sel,
	input wire logic        bus_width_reserved,
	input wire logic [2:0]  ref_freq_sel,
	input wire logic        freq_unsupported,
	input wire logic        config_valid,
	input wire logic        use_ref_as_boot_clock
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [8:0] cfg;
	assign cfg = {boot_internal, rf_integrated, boot_clock_sel, bus_width_reserved,
		ref_freq_sel, freq_unsupported};
	AST_RESET_CFG: assert property (disable iff (1'b0) !presetn |->
		cfg == RSBC_CFG_RESET && !config_valid) else $error("config not default in reset");
	AST_CAPTURE_TIME: assert property ($rose(presetn) |->
		!config_valid ##[1:2] config_valid) else $error("config not valid in time");
	AST_CFG_HELD: assert property (config_valid |=> config_valid && $stable(cfg))
		else $error("latched config changed");
	AST_UNSUP_FLAG: assert property (config_valid |->
		freq_unsupported == (ref_freq_sel == RSBC_F_NONE)) else $error("unsupported flag wrong");
	AST_BOOTCLK_DEFAULT: assert property ($rose(presetn) |->
		use_ref_as_boot_clock [*2]) else $error("reference boot clock not default");
	AST_READY_ANSWER: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready too long");
	AST_ERR_UNMAPPED: assert property (psel && !penable && paddr > 12'h00C |=> pslverr)
		else $error("no error on unmapped address");
	AST_ERR_ONLY_READY: assert property (pslverr |-> pready) else $error("error without ready");
	cover property ($rose(config_valid));
	cover property (pslverr);
	cover property (config_valid && freq_unsupported);
endmodule
bind rsbc_top rsbc_top_props i_rsbc_top_props (.pclk, .presetn, .psel, .penable, .paddr,
	.pready, .pslverr, .boot_internal, .rf_integrated, .boot_clock_sel, .bus_width_reserved,
	.ref_freq_sel, .freq_unsupported, .config_valid, .use_ref_as_boot_clock);
`default_nettype wire

/* File: bench/rsbc_board.sv */
`timescale 1ns/1ps
`default_nettype none
module rsbc_board
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [13:0] strap_val,
	input  wire logic [13:0] fit_mask,
	output logic      [13:0] data_bus_in,
	output logic      [13:0] data_bus_drive
);
	logic [13:0] traffic_reg;
	logic [13:0] traffic_next;
	logic        run_reg;
	logic        run_next;
	always_comb
	begin
		traffic_next = ~traffic_reg;
		run_next = 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			traffic_reg <= 14'h1555;
			run_reg <= 1'b0;
		end
		else
		begin
			traffic_reg <= traffic_next;
			run_reg <= run_next;
		end
	end
	// Resistors hold straps until first edge after release, then bus traffic
	assign data_bus_drive = fit_mask;
	assign data_bus_in = run_reg ? traffic_reg : (strap_val & fit_mask) | (~strap_val & ~fit_mask);
endmodule
`default_nettype wire

/* File: bench/rsbc_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rsbc_top_test
	import rsbc_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [13:0] bus_in;
	logic [13:0] bus_drv;
	logic [13:0] strap_val = 14'h0;
	logic [13:0] fit_mask = 14'h0;
	logic [1:0]  tst = 2'h0;
	logic [8:0]  cfg_o;
	logic        cfg_valid;
	logic        use_ref;
	logic [31:0] rd;
	logic        er;
	logic [8:0]  x;
	int          bad_count = 0;
	int          n_compared = 0;
	integer      seed = 32'h3AB9;
	logic [1:0]  tst_tab [7] = '{2'h1, 2'h3, 2'h0, 2'h3, 2'h3, 2'h2, 2'h3};
	logic [4:0]  ext_tab [7] = '{5'h15, 5'h00, 5'h0A, 5'h08, 5'h0D, 5'h1F, 5'h1E};
	always #10 pclk = ~pclk;
	rsbc_top i_rsbc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .data_bus_in(bus_in), .data_bus_drive(bus_drv),
		.test_clock_freq_strap(tst[1]), .test_datain_freq_strap(tst[0]),
		.boot_internal(cfg_o[8]), .rf_integrated(cfg_o[7]), .boot_clock_sel(cfg_o[6:5]),
		.bus_width_reserved(cfg_o[4]), .ref_freq_sel(cfg_o[3:1]),
		.freq_unsupported(cfg_o[0]), .config_valid(cfg_valid), .use_ref_as_boot_clock(use_ref));
	rsbc_board i_rsbc_board (.pclk(pclk), .presetn(presetn), .strap_val(strap_val),
		.fit_mask(fit_mask), .data_bus_in(bus_in), .data_bus_drive(bus_drv));
	function automatic logic [8:0] exp_cfg(input logic [13:0] v, m, input logic [1:0] t);
		logic [13:0] e;
		logic [2:0]  f;
		e = (v & m) | (~m & RSBC_PULLUP_MASK);
		case (t)
			RSBC_TST_01: f = RSBC_F_24P5535;
			RSBC_TST_00: f = RSBC_F_16P369;
			RSBC_TST_10: f = RSBC_F_26P0;
			default:
			case (e[13:9])
				RSBC_EXT_13P0: f = RSBC_F_13P0;
				RSBC_EXT_16P8: f = RSBC_F_16P8;
				RSBC_EXT_19P2: f = RSBC_F_19P2;
				RSBC_EXT_33P6: f = RSBC_F_33P6;
				default: f = RSBC_F_NONE;
			endcase
		endcase
		return {e[0], e[1], e[3:2], e[7], f, f == RSBC_F_NONE};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wait_bad(input logic ok);
		if (!ok)
		begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		i = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		rd = prdata;
		er = pslverr;
		wait_bad(pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic boot(input logic [13:0] v, m, input logic [1:0] t);
		int i;
		i = 0;
		presetn <= 1'b0;
		strap_val <= v;
		fit_mask <= m;
		tst <= t;
		repeat (4) @(posedge pclk);
		@(negedge pclk);
		check(32'(cfg_o), 32'(RSBC_CFG_RESET));
		@(posedge pclk);
		presetn <= 1'b1;
		while (cfg_valid !== 1'b1 && i < 20)
		begin
			@(negedge pclk);
			i++;
		end
		wait_bad(cfg_valid === 1'b1);
		check(32'(cfg_o), 32'(x));
		@(posedge pclk);
		strap_val <= ~v;
		tst <= ~t;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		check(32'(cfg_o), 32'(x));
		@(posedge pclk);
	endtask
	initial
	begin
		logic [13:0] v;
		logic [13:0] m;
		logic [1:0]  t;
		for (int n = 0; n < 24; n++)
		begin
			v = n < 7 ? {ext_tab[n], 9'h00E} : 14'($random(seed));
			m = n < 7 ? 14'h3FFF : 14'($random(seed));
			t = n < 7 ? tst_tab[n] : 2'($random(seed));
			x = exp_cfg(v, m, t);
			boot(v, m, t);
			apb(1'b0, RSBC_ADDR_CONFIG, 32'h0);
			check(rd, {26'h0, x[4], x[6:5], x[7], x[8], 1'b1});
			apb(1'b1, RSBC_ADDR_CONFIG, 32'hFFFFFFFF);
			apb(1'b0, RSBC_ADDR_FREQ, 32'h0);
			check(rd, {28'h0, x[0], x[3:1]});
			apb(1'b0, RSBC_ADDR_STRAPS, 32'h0);
			check(rd, {16'h0, t, (v & m) | (~m & RSBC_PULLUP_MASK)});
			$display("test %0d done", n);
		end
		apb(1'b0, RSBC_ADDR_CONFIG, 32'h0);
		check(rd, {26'h0, x[4], x[6:5], x[7], x[8], 1'b1});
		apb(1'b0, RSBC_ADDR_CTRL, 32'h0);
		check(rd, 32'h1);
		apb(1'b1, RSBC_ADDR_CTRL, 32'h0);
		apb(1'b0, RSBC_ADDR_CTRL, 32'h0);
		check(rd, 32'h0);
		check({31'h0, use_ref}, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check({31'h0, er}, 32'h1);
		$display("test registers done");
		complete_run();
	end
endmodule
`default_nettype wire
